// file: shared/usm_defines.svh
`ifndef USM_DEFINES_SVH
`define USM_DEFINES_SVH

// command register field layout: phase in 15:8, code/write data in 23:16
`define USM_PHASE_LSB 8
`define USM_PHASE_MSB 15
`define USM_CODE_LSB 16
`define USM_CODE_MSB 23

// command phases
`define USM_PHASE_COMMAND 8'h05
`define USM_PHASE_WRITE 8'h01
`define USM_PHASE_READ 8'h02

// command codes handled here
`define USM_CMD_CONFIGURE 8'hD8
`define USM_CMD_SET_MODE 8'hF3

// configure byte fields
`define USM_CONF_BIT 0

// set-mode byte fields
`define USM_MODE_ALWAYS_CLK 0
`define USM_MODE_NAK_CI 1
`define USM_MODE_NAK_CO 2
`define USM_MODE_NAK_AI 3
`define USM_MODE_NAK_AO 4

// width of the stored mode fields
`define USM_MODE_WIDTH 5

// reset values
`define USM_CONF_RESET 1'h0
`define USM_MODE_RESET 5'h00
`define USM_EMPTY_RESET 1'h1
`define USM_LED_RESET 1'h1
`define USM_CLK_REQ_RESET 1'h1
`define USM_IRQ_RESET 1'h0

`endif

// file: shared/usm_pkg.sv
`default_nettype none
package usm_pkg;

  // command sequencer states, one-hot
  typedef enum logic [2:0] {
    USM_IDLE = 3'h1,
    USM_WAIT_DATA = 3'h2,
    USM_DONE = 3'h4
  } usm_state_type;

  // which setting the pending data phase targets
  typedef enum logic [1:0] {
    USM_TGT_NONE = 2'h0,
    USM_TGT_CONF = 2'h1,
    USM_TGT_MODE = 2'h2
  } usm_target_type;

endpackage
`default_nettype wire

// file: verilog/usm_sie_config_mode.sv
// Function
// - bit 0 written one marks device configured
// - bus reset clears the configured flag
// - led low when configured and not suspended
// - set-mode is code F3, one write byte
// - always-clock zero: clock request follows activity
// - always-clock one: clock request held high
// - control IN NAKs interrupt when enabled
// - control OUT NAKs interrupt when enabled
// - int/bulk IN NAKs interrupt when enabled
// - int/bulk OUT NAKs interrupt when enabled
// - disabled class: only successful transactions interrupt
// - int/bulk IN at bit 3, OUT bit 4
// - command then write phase; empty flag on completion
`timescale 1ns/10ps
`default_nettype none
`include "usm_defines.svh"

module usm_sie_config_mode (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command register write port
  input wire logic cmd_wr_stb,
  input wire logic [31:0] cmd_wr_data,
  // link state from the serial engine (same clock)
  input wire logic bus_reset,
  input wire logic suspend_indication,
  input wire logic clock_activity_need,
  // endpoint transaction events (same clock), one-cycle pulses
  input wire logic ep_ctrl_in_done,
  input wire logic ep_ctrl_out_done,
  input wire logic ep_ib_in_done,
  input wire logic ep_ib_out_done,
  input wire logic ep_nak,
  // status and settings
  output logic command_empty_flag,
  output logic configured_flag,
  output logic [4:0] mode_fields,
  // pins and interrupt request
  output logic connect_indicator_led,
  output logic clock_request_output,
  output logic ep_irq_pulse
);

  // sequencer and setting registers
  usm_pkg::usm_state_type state_reg, state_next;
  usm_pkg::usm_target_type target_reg, target_next;
  logic conf_reg, conf_next;
  logic [4:0] mode_reg, mode_next;
  logic empty_reg, empty_next;
  // pin and interrupt flip-flops
  logic led_reg, clk_req_reg, irq_reg;

  // command register fields
  wire [7:0] phase = cmd_wr_data[`USM_PHASE_MSB:`USM_PHASE_LSB];
  wire [7:0] code = cmd_wr_data[`USM_CODE_MSB:`USM_CODE_LSB];

  // recognised phases and commands
  wire is_cmd = cmd_wr_stb && (phase == `USM_PHASE_COMMAND);
  wire is_wr = cmd_wr_stb && (phase == `USM_PHASE_WRITE);
  wire cmd_conf = is_cmd && (code == `USM_CMD_CONFIGURE);
  wire cmd_mode = is_cmd && (code == `USM_CMD_SET_MODE);
  wire cmd_known = cmd_conf || cmd_mode;
  wire data_ok = is_wr && (state_reg == usm_pkg::USM_WAIT_DATA);

  // write data fields; reserved bits are never stored
  wire wr_conf_bit = cmd_wr_data[`USM_CODE_LSB + `USM_CONF_BIT];
  wire [4:0] wr_mode_bits = cmd_wr_data[`USM_CODE_LSB +: `USM_MODE_WIDTH];

  // per-class interrupt permission: success always, nak only if enabled
  wire nak_ci = mode_reg[`USM_MODE_NAK_CI];
  wire nak_co = mode_reg[`USM_MODE_NAK_CO];
  wire nak_ai = mode_reg[`USM_MODE_NAK_AI];
  wire nak_ao = mode_reg[`USM_MODE_NAK_AO];

  // a nak only counts alongside a done pulse of its class
  wire irq_ci = ep_ctrl_in_done && (!ep_nak || nak_ci);
  wire irq_co = ep_ctrl_out_done && (!ep_nak || nak_co);
  wire irq_ai = ep_ib_in_done && (!ep_nak || nak_ai);
  wire irq_ao = ep_ib_out_done && (!ep_nak || nak_ao);
  wire irq_any = irq_ci | irq_co | irq_ai | irq_ao;

  // led active low; only driven low while configured and awake
  // one cycle of lag keeps the pin free of decode glitches
  wire led_next = !(conf_reg && !suspend_indication);
  // forcing the request high keeps the 48 MHz clock through suspend
  wire clk_req_next = mode_reg[`USM_MODE_ALWAYS_CLK] ? 1'h1 : clock_activity_need;

  // command sequencer: a command phase arms a target, a write phase lands it
  // commands are taken in any state, so a stray one never leaves the flag low
  // software must see the empty flag high before it sends the write phase
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    conf_next = conf_reg;
    mode_next = mode_reg;
    empty_next = empty_reg;
    if (cmd_known) begin
      // a new command abandons any pending data phase
      target_next = cmd_conf ? usm_pkg::USM_TGT_CONF : usm_pkg::USM_TGT_MODE;
      state_next = usm_pkg::USM_DONE;
      empty_next = 1'h0;
    end else if (is_cmd) begin
      // unknown codes complete at once but arm nothing
      target_next = usm_pkg::USM_TGT_NONE;
      state_next = usm_pkg::USM_IDLE;
      empty_next = 1'h1;
    end else begin
      case (state_reg)
        usm_pkg::USM_IDLE: begin
          // a write phase with nothing armed is dropped
          target_next = usm_pkg::USM_TGT_NONE;
        end
        usm_pkg::USM_WAIT_DATA: begin
          if (data_ok) begin
            // only the armed setting takes the byte
            if (target_reg == usm_pkg::USM_TGT_CONF) begin
              conf_next = wr_conf_bit;
            end else if (target_reg == usm_pkg::USM_TGT_MODE) begin
              mode_next = wr_mode_bits;
            end
            target_next = usm_pkg::USM_TGT_NONE;
            empty_next = 1'h1;
            state_next = usm_pkg::USM_IDLE;
          end
        end
        usm_pkg::USM_DONE: begin
          // command phase finished one cycle after it was taken
          empty_next = 1'h1;
          state_next = usm_pkg::USM_WAIT_DATA;
        end
        default: begin
          state_next = usm_pkg::USM_IDLE;
          target_next = usm_pkg::USM_TGT_NONE;
          empty_next = 1'h1;
        end
      endcase
    end
    // bus reset wins over any write landing in the same cycle
    if (bus_reset) begin
      conf_next = `USM_CONF_RESET;
      mode_next = `USM_MODE_RESET;
    end
  end

  // sequencer state and pending target
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= usm_pkg::USM_IDLE;
      target_reg <= usm_pkg::USM_TGT_NONE;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
    end
  end

  // configured flag, cleared by either reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conf_reg <= `USM_CONF_RESET;
    end else begin
      conf_reg <= conf_next;
    end
  end

  // mode fields; zero means stoppable clock, success-only interrupts
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_reg <= `USM_MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // command-empty flag, high while no command is in progress
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      empty_reg <= `USM_EMPTY_RESET;
    end else begin
      empty_reg <= empty_next;
    end
  end

  // connect led, dark through reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      led_reg <= `USM_LED_RESET;
    end else begin
      led_reg <= led_next;
    end
  end

  // clock request, high through reset so the clock survives start-up
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_req_reg <= `USM_CLK_REQ_RESET;
    end else begin
      clk_req_reg <= clk_req_next;
    end
  end

  // endpoint interrupt pulse, one cycle after the qualifying event
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_reg <= `USM_IRQ_RESET;
    end else begin
      irq_reg <= irq_any;
    end
  end

  // outputs straight from the flip-flops
  assign command_empty_flag = empty_reg;
  assign configured_flag = conf_reg;
  assign mode_fields = mode_reg;
  assign connect_indicator_led = led_reg;
  assign clock_request_output = clk_req_reg;
  assign ep_irq_pulse = irq_reg;

endmodule

`default_nettype wire

// file: tb/usm_props.sv
`timescale 1ns/10ps
`default_nettype none
module usm_props (
  // clock, reset and stimulus
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_wr_stb,
  input wire logic [31:0] cmd_wr_data,
  input wire logic bus_reset,
  input wire logic suspend_indication,
  input wire logic clock_activity_need,
  input wire logic ep_ctrl_in_done,
  input wire logic ep_ctrl_out_done,
  input wire logic ep_ib_in_done,
  input wire logic ep_ib_out_done,
  input wire logic ep_nak,
  // outputs watched
  input wire logic command_empty_flag,
  input wire logic configured_flag,
  input wire logic [4:0] mode_fields,
  input wire logic connect_indicator_led,
  input wire logic clock_request_output,
  input wire logic ep_irq_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a naked transaction only counts where its class opts in
  wire logic irq_due = |({ep_ib_out_done, ep_ib_in_done, ep_ctrl_out_done, ep_ctrl_in_done}
    & (~{4{ep_nak}} | mode_fields[4:1]));
  conf_set_a: assert property ($rose(configured_flag) |-> $past(cmd_wr_stb) && $past(cmd_wr_data[16]))
    else $error("configured without write");
  bus_clear_a: assert property (bus_reset |=> !configured_flag && mode_fields == 5'h00)
    else $error("bus reset kept settings");
  led_drive_a: assert property (connect_indicator_led == !($past(configured_flag) && !$past(suspend_indication)))
    else $error("led level wrong");
  clk_req_a: assert property ($past(rst_n) |-> clock_request_output == ($past(mode_fields[0]) || $past(clock_activity_need)))
    else $error("clock request wrong");
  irq_gate_a: assert property (ep_irq_pulse == $past(irq_due))
    else $error("endpoint interrupt wrong");
  cmd_busy_a: assert property (cmd_wr_stb && cmd_wr_data[15:8] == 8'h05 && cmd_wr_data[23:16] inside {8'hD8, 8'hF3}
    |=> !command_empty_flag ##1 command_empty_flag) else $error("command phase timing wrong");
  mode_wr_a: assert property ($changed(mode_fields) && !$past(bus_reset)
    |-> $past(cmd_wr_stb) && mode_fields == $past(cmd_wr_data[20:16])) else $error("mode changed wrongly");
  wr_done_a: assert property (cmd_wr_stb && cmd_wr_data[15:8] == 8'h01 |=> command_empty_flag)
    else $error("write phase left busy");
endmodule
bind usm_sie_config_mode usm_props chk_i (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .cmd_wr_stb(cmd_wr_stb),
  .cmd_wr_data(cmd_wr_data),
  .bus_reset(bus_reset),
  .suspend_indication(suspend_indication),
  .clock_activity_need(clock_activity_need),
  .ep_ctrl_in_done(ep_ctrl_in_done),
  .ep_ctrl_out_done(ep_ctrl_out_done),
  .ep_ib_in_done(ep_ib_in_done),
  .ep_ib_out_done(ep_ib_out_done),
  .ep_nak(ep_nak),
  .command_empty_flag(command_empty_flag),
  .configured_flag(configured_flag),
  .mode_fields(mode_fields),
  .connect_indicator_led(connect_indicator_led),
  .clock_request_output(clock_request_output),
  .ep_irq_pulse(ep_irq_pulse)
);
`default_nettype wire

// file: tb/usm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module usm_host_model (
  // clock
  input wire logic core_clk,
  // bus state and transaction events
  output logic bus_reset,
  output logic [3:0] done,
  output logic ep_nak
);
  // quiet bus until a task drives traffic
  initial begin
    bus_reset = 1'h0;
    done = 4'h0;
    ep_nak = 1'h0;
  end
  // one transaction of class c, naked or not
  task automatic xfer(input int c, input logic n);
    @(negedge core_clk) done[c] = 1'h1;
    ep_nak = n;
    @(negedge core_clk) done = 4'h0;
    ep_nak = 1'h0;
  endtask
  // one cycle of bus reset
  task automatic reset_bus();
    @(negedge core_clk) bus_reset = 1'h1;
    @(negedge core_clk) bus_reset = 1'h0;
  endtask
endmodule
`default_nettype wire

// file: tb/usm_sie_config_mode_bench.sv
`timescale 1ns/10ps
`default_nettype none
module usm_sie_config_mode_bench;
  logic core_clk = 1'h0, rst_n = 1'h0, cmd_wr_stb = 1'h0, suspend_indication = 1'h0, clock_activity_need = 1'h0;
  logic [31:0] cmd_wr_data = 32'h0;
  wire logic bus_reset, ep_ctrl_in_done, ep_ctrl_out_done, ep_ib_in_done, ep_ib_out_done, ep_nak;
  wire logic command_empty_flag, configured_flag, connect_indicator_led, clock_request_output, ep_irq_pulse;
  wire logic [4:0] mode_fields;
  int failures = 0, samples_checked = 0;
  usm_host_model host (.core_clk, .bus_reset, .ep_nak,
    .done({ep_ib_out_done, ep_ib_in_done, ep_ctrl_out_done, ep_ctrl_in_done}));
  usm_sie_config_mode DUT (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cmd_wr_stb(cmd_wr_stb),
    .cmd_wr_data(cmd_wr_data),
    .bus_reset(bus_reset),
    .suspend_indication(suspend_indication),
    .clock_activity_need(clock_activity_need),
    .ep_ctrl_in_done(ep_ctrl_in_done),
    .ep_ctrl_out_done(ep_ctrl_out_done),
    .ep_ib_in_done(ep_ib_in_done),
    .ep_ib_out_done(ep_ib_out_done),
    .ep_nak(ep_nak),
    .command_empty_flag(command_empty_flag),
    .configured_flag(configured_flag),
    .mode_fields(mode_fields),
    .connect_indicator_led(connect_indicator_led),
    .clock_request_output(clock_request_output),
    .ep_irq_pulse(ep_irq_pulse)
  );
  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // optional command phase, then the write phase; settings settle on return
  task automatic wr(input logic [7:0] code, input logic [7:0] val, input bit cmd);
    if (cmd) begin
      @(negedge core_clk) cmd_wr_stb = 1'h1;
      cmd_wr_data = {8'h00, code, 8'h05, 8'h00};
      @(negedge core_clk) cmd_wr_stb = 1'h0;
      @(negedge core_clk);
      for (int i = 0; i < 8 && command_empty_flag !== 1'h1; i++) @(negedge core_clk);
      chk(command_empty_flag, 1'h1);
    end
    @(negedge core_clk) cmd_wr_stb = 1'h1;
    cmd_wr_data = {8'h00, val, 8'h01, 8'h00};
    @(negedge core_clk) cmd_wr_stb = 1'h0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'h1;
    chk({command_empty_flag, configured_flag, connect_indicator_led, mode_fields}, 8'hA0);
    wr(8'hD8, 8'h01, 1);
    @(negedge core_clk);
    chk({configured_flag, connect_indicator_led}, 8'h02);
    suspend_indication = 1'h1;
    @(negedge core_clk);
    chk(connect_indicator_led, 1'h1);
    suspend_indication = 1'h0;
    wr(8'hD8, 8'h00, 1);
    chk(configured_flag, 1'h0);
    $display("configure test done");
    for (int c = 0; c < 4; c++) begin
      wr(8'hF3, 8'h00, 1);
      host.xfer(c, 1'h1);
      chk(ep_irq_pulse, 1'h0);
      host.xfer(c, 1'h0);
      chk(ep_irq_pulse, 1'h1);
      wr(8'hF3, 8'h02 << c, 1);
      chk(mode_fields, 8'h02 << c);
      host.xfer(c, 1'h1);
      chk(ep_irq_pulse, 1'h1);
    end
    $display("nak test done");
    wr(8'hF3, 8'h01, 1);
    @(negedge core_clk);
    chk(clock_request_output, 1'h1);
    wr(8'hF3, 8'h00, 1);
    @(negedge core_clk);
    chk(clock_request_output, 1'h0);
    clock_activity_need = 1'h1;
    @(negedge core_clk);
    chk(clock_request_output, 1'h1);
    clock_activity_need = 1'h0;
    @(negedge core_clk);
    chk(clock_request_output, 1'h0);
    wr(8'hF3, 8'h1F, 0);
    chk(mode_fields, 8'h00);
    wr(8'hD0, 8'h1F, 1);
    chk(mode_fields, 8'h00);
    wr(8'hD8, 8'h01, 1);
    wr(8'hF3, 8'h1F, 1);
    host.reset_bus();
    chk({configured_flag, mode_fields}, 8'h00);
    $display("clock and reset test done");
    finish_test();
  end
  // hang guard, far beyond the roughly 130 cycles needed
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
